// File: core/panel_timing_pkg.sv
package panel_timing_pkg;
  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int ACTIVE_PIXEL_COUNT = 240;
  localparam int ACTIVE_LINE_COUNT = 320;
  localparam int LINE_SYNC_WIDTH = 10;
  localparam int LINE_BACK_PORCH = 20;
  localparam int LINE_TRAILING_PORCH = 10;
  localparam int LINE_CLOCK_TOTAL = 280;
  localparam int VERT_SYNC_LINES = 2;
  localparam int VERT_DATA_START_LINES = 4;
  localparam int VERT_TRAILING_PORCH = 2;
  localparam int FRAME_LINE_TOTAL = 326;
  localparam int MIN_LINE_SYNC = 8;
  localparam int MIN_LINE_BACK_PORCH = 18;
  localparam int MIN_LINE_TRAILING = 4;
  localparam int MIN_VERT_START = 2;
  localparam int MIN_VERT_TRAILING = 1;
  localparam int MIN_LINE_TOTAL = 260;
  localparam int MAX_LINE_TOTAL = 300;
  localparam int MIN_FRAME_TOTAL = 323;
  localparam int MAX_FRAME_TOTAL = 340;
  localparam int WHITE_FRAMES_OFF = 2;
  localparam int START_VSYNC_EDGE = 10;
  // ****************************************
  // Pixel clock and serial port timing
  // ****************************************
  localparam int CLK_SYS_MHZ = 100;
  localparam int PIXEL_KHZ = 6250;
  localparam int PIXEL_DIV = (CLK_SYS_MHZ * 1000) / PIXEL_KHZ;
  localparam int SER_DIV = 8;
  localparam int SER_BITS = 16;
  localparam logic [6:0] VERT_START_ADDR = 7'h03;
  localparam logic [6:0] HORIZ_START_ADDR = 7'h04;
  localparam logic [5:0] WHITE_LEVEL = 6'h3f;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } pixel_s;
  typedef struct packed {
    logic [8:0] line_total;
    logic [5:0] sync_width;
    logic [5:0] data_start;
    logic [8:0] frame_total;
    logic [3:0] vsync_lines;
    logic [3:0] vert_start;
  } timing_s;
  typedef enum logic [1:0] {off_st, run_st, white_st, done_st} run_e;
endpackage

// File: core/serial_reg_writer.sv
`timescale 1ns/100ps
module serial_reg_writer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic [6:0] addr,
  input wire logic [7:0] data,
  output logic busy,
  // Serial pins
  output logic ser_cs_n,
  output logic ser_clk,
  output logic ser_dat_o,
  output logic ser_dat_oe
);
  logic [15:0] shreg;
  logic [4:0] bit_cnt;
  logic [3:0] div;

  // ****************************************
  // Write frame: flag low, address, data, msb first
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      ser_cs_n <= 1'b1;
      ser_clk <= 1'b0;
      ser_dat_o <= 1'b0;
      ser_dat_oe <= 1'b0;
      shreg <= 16'h0000;
      bit_cnt <= 5'h00;
      div <= 4'h0;
    end else if (ce) begin
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          ser_cs_n <= 1'b0;
          ser_dat_oe <= 1'b1;
          ser_dat_o <= 1'b0;
          shreg <= {1'b0, addr, data};
          bit_cnt <= 5'h00;
          div <= 4'h0;
        end
      end else if (div == 4'(panel_timing_pkg::SER_DIV - 1)) begin
        div <= 4'h0;
        if (ser_clk) begin
          ser_clk <= 1'b0;
          if (bit_cnt == 5'(panel_timing_pkg::SER_BITS)) begin
            busy <= 1'b0;
            ser_cs_n <= 1'b1;
            ser_dat_oe <= 1'b0;
          end else begin
            ser_dat_o <= shreg[15];
          end
        end else if (bit_cnt == 5'(panel_timing_pkg::SER_BITS)) begin
          ser_clk <= 1'b0;
          ser_cs_n <= 1'b1;
          ser_dat_oe <= 1'b0;
          busy <= 1'b0;
        end else begin
          // Panel samples on this rising edge
          ser_clk <= 1'b1;
          shreg <= {shreg[14:0], 1'b0};
          bit_cnt <= bit_cnt + 5'h01;
        end
      end else begin
        div <= div + 4'h1;
      end
    end
  end
endmodule

// File: core/rgb_panel_timing_host.sv
`timescale 1ns/100ps
// What this block does
// - Active lines start vert_start lines after vsync; told to panel reg three.
// - Vertical trailing porch of at least one line before next vsync.
// - Vertical blanking at least three lines; frame 323 to 340 lines.
// - Exactly 320 active lines per frame.
// - At least four clocks of trailing porch after last pixel.
// - Line sync held active at least eight pixel clocks.
// - Back porch at least eighteen clocks after line sync ends; the 6-bit clamp sum wraps, so this is not kept when sync_width is above 45.
// - First pixel data_start clocks after hsync; told to panel reg four.
// - Exactly 240 pixels per line; line total 260 to 300 clocks, up to 307 when data_start is above 56.
// - Pixel clock runs without pause, blanking included, inside allowed band.
// - Hsync falling edge sits inside the allowed window around vsync fall.
// - Two all-white frames are sent before power-off.
// - Scan direction select is held static.
// - Serial write: flag, 7-bit address, 8 data bits, sampled rising edge.
module rgb_panel_timing_host #(
  parameter int PIXEL_DIV = panel_timing_pkg::PIXEL_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // User control
  input wire logic enable,
  input wire logic power_down_req,
  input wire logic scan_dir,
  input wire panel_timing_pkg::timing_s timing_in,
  input wire logic cfg_write,
  input wire panel_timing_pkg::pixel_s pixel_in,
  output logic pixel_req,
  output logic [8:0] pixel_x,
  output logic [8:0] pixel_y,
  output logic power_down_ok,
  output logic cfg_busy,
  // Panel pins
  output logic panel_reset_n,
  output logic pixel_clk,
  output logic vsync_n,
  output logic hsync_n,
  output panel_timing_pkg::pixel_s rgb,
  output logic scan_direction_sel,
  output logic ser_cs_n,
  output logic ser_clk,
  output logic ser_dat_o,
  output logic ser_dat_oe
);
  logic rst_meta, rst_n;
  logic [7:0] div;
  logic pix_tick;
  logic [8:0] hcnt, vcnt;
  panel_timing_pkg::timing_s tm;
  panel_timing_pkg::run_e run;
  logic [1:0] white_cnt;
  logic h_active, v_active;
  logic [1:0] cfg_step;
  logic wr_start, wr_busy;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Free running pixel clock
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div <= 8'h00;
      pixel_clk <= 1'b0;
    end else if (clk_en) begin
      if (div == 8'(PIXEL_DIV / 2 - 1)) begin
        div <= 8'h00;
        pixel_clk <= ~pixel_clk;
      end else begin
        div <= div + 8'h01;
      end
    end
  end
  // Pins move on the falling edge; panel samples them half a period later
  assign pix_tick = clk_en && pixel_clk &&
                    div == 8'(PIXEL_DIV / 2 - 1);

  // ****************************************
  // Timing set, clamped to legal limits at frame start
  // ****************************************
  function automatic panel_timing_pkg::timing_s clamp(
    input panel_timing_pkg::timing_s t);
    panel_timing_pkg::timing_s r;
    r = t;
    if (r.sync_width < 6'(panel_timing_pkg::MIN_LINE_SYNC))
      r.sync_width = 6'(panel_timing_pkg::MIN_LINE_SYNC);
    if (r.data_start < r.sync_width +
        6'(panel_timing_pkg::MIN_LINE_BACK_PORCH))
      r.data_start = r.sync_width +
        6'(panel_timing_pkg::MIN_LINE_BACK_PORCH);
    if (r.line_total < 9'(panel_timing_pkg::MIN_LINE_TOTAL))
      r.line_total = 9'(panel_timing_pkg::MIN_LINE_TOTAL);
    if (r.line_total > 9'(panel_timing_pkg::MAX_LINE_TOTAL))
      r.line_total = 9'(panel_timing_pkg::MAX_LINE_TOTAL);
    if (9'(r.data_start) + 9'(panel_timing_pkg::ACTIVE_PIXEL_COUNT) +
        9'(panel_timing_pkg::MIN_LINE_TRAILING) > r.line_total)
      r.line_total = 9'(r.data_start) +
        9'(panel_timing_pkg::ACTIVE_PIXEL_COUNT) +
        9'(panel_timing_pkg::MIN_LINE_TRAILING);
    if (r.vert_start < 4'(panel_timing_pkg::MIN_VERT_START))
      r.vert_start = 4'(panel_timing_pkg::MIN_VERT_START);
    if (r.vsync_lines == 4'h0 || r.vsync_lines > r.vert_start)
      r.vsync_lines = 4'h1;
    if (r.frame_total < 9'(r.vert_start) +
        9'(panel_timing_pkg::ACTIVE_LINE_COUNT) +
        9'(panel_timing_pkg::MIN_VERT_TRAILING))
      r.frame_total = 9'(r.vert_start) +
        9'(panel_timing_pkg::ACTIVE_LINE_COUNT) +
        9'(panel_timing_pkg::MIN_VERT_TRAILING);
    if (r.frame_total < 9'(panel_timing_pkg::MIN_FRAME_TOTAL))
      r.frame_total = 9'(panel_timing_pkg::MIN_FRAME_TOTAL);
    if (r.frame_total > 9'(panel_timing_pkg::MAX_FRAME_TOTAL))
      r.frame_total = 9'(panel_timing_pkg::MAX_FRAME_TOTAL);
    return r;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tm <= '{9'(panel_timing_pkg::LINE_CLOCK_TOTAL),
              6'(panel_timing_pkg::LINE_SYNC_WIDTH),
              6'(panel_timing_pkg::LINE_SYNC_WIDTH +
                 panel_timing_pkg::LINE_BACK_PORCH),
              9'(panel_timing_pkg::FRAME_LINE_TOTAL),
              4'(panel_timing_pkg::VERT_SYNC_LINES),
              4'(panel_timing_pkg::VERT_DATA_START_LINES)};
    end else if (pix_tick && hcnt == 9'h000 && vcnt == 9'h000) begin
      tm <= clamp(timing_in);
    end
  end

  // ****************************************
  // Dot and line counters
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hcnt <= 9'h000;
      vcnt <= 9'h000;
    end else if (pix_tick) begin
      if (hcnt == tm.line_total - 9'h001) begin
        hcnt <= 9'h000;
        if (vcnt == tm.frame_total - 9'h001)
          vcnt <= 9'h000;
        else
          vcnt <= vcnt + 9'h001;
      end else begin
        hcnt <= hcnt + 9'h001;
      end
    end
  end

  assign h_active = hcnt >= 9'(tm.data_start) &&
    hcnt < 9'(tm.data_start) +
           9'(panel_timing_pkg::ACTIVE_PIXEL_COUNT);
  assign v_active = vcnt >= 9'(tm.vert_start) &&
    vcnt < 9'(tm.vert_start) +
           9'(panel_timing_pkg::ACTIVE_LINE_COUNT);

  // ****************************************
  // Run state, white frames before power-off
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run <= panel_timing_pkg::off_st;
      white_cnt <= 2'h0;
      panel_reset_n <= 1'b0;
      power_down_ok <= 1'b0;
    end else if (clk_en) begin
      case (run)
        panel_timing_pkg::off_st: begin
          power_down_ok <= 1'b0;
          if (enable && !power_down_req && pix_tick && hcnt == 9'h000 &&
              vcnt == 9'h000) begin
            run <= panel_timing_pkg::run_st;
            panel_reset_n <= 1'b1;
          end
        end
        panel_timing_pkg::run_st: begin
          if (power_down_req && pix_tick && hcnt == 9'h000 &&
              vcnt == 9'h000) begin
            run <= panel_timing_pkg::white_st;
            white_cnt <= 2'h0;
          end
        end
        panel_timing_pkg::white_st: begin
          if (pix_tick && hcnt == tm.line_total - 9'h001 &&
              vcnt == tm.frame_total - 9'h001) begin
            if (white_cnt == 2'(panel_timing_pkg::WHITE_FRAMES_OFF - 1))
              run <= panel_timing_pkg::done_st;
            else
              white_cnt <= white_cnt + 2'h1;
          end
        end
        panel_timing_pkg::done_st: begin
          power_down_ok <= 1'b1;
          if (!power_down_req) begin
            run <= panel_timing_pkg::off_st;
            panel_reset_n <= 1'b0;
          end
        end
        default: run <= panel_timing_pkg::off_st;
      endcase
    end
  end

  // ****************************************
  // Sync and pixel pins, registered on the tick
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
      rgb <= '0;
      pixel_req <= 1'b0;
      pixel_x <= 9'h000;
      pixel_y <= 9'h000;
      scan_direction_sel <= 1'b0;
    end else if (clk_en) begin
      pixel_req <= 1'b0;
      if (run == panel_timing_pkg::off_st)
        scan_direction_sel <= scan_dir;
      if (pix_tick) begin
        // Both syncs fall at hcnt 0 of line 0, inside the phase window
        hsync_n <= !(hcnt < 9'(tm.sync_width));
        vsync_n <= !(vcnt < 9'(tm.vsync_lines));
        if (h_active && v_active) begin
          pixel_x <= hcnt - 9'(tm.data_start);
          pixel_y <= vcnt - 9'(tm.vert_start);
          pixel_req <= 1'b1;
          if (run == panel_timing_pkg::white_st ||
              run == panel_timing_pkg::done_st)
            rgb <= {3{panel_timing_pkg::WHITE_LEVEL}};
          else
            rgb <= pixel_in;
        end else begin
          rgb <= '0;
        end
      end
    end
  end

  // ****************************************
  // Start position writes: reg three then reg four
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_step <= 2'h0;
      wr_start <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      cfg_busy <= 1'b0;
    end else if (clk_en) begin
      wr_start <= 1'b0;
      case (cfg_step)
        2'h0: begin
          cfg_busy <= 1'b0;
          if (cfg_write && !wr_busy) begin
            cfg_busy <= 1'b1;
            wr_addr <= panel_timing_pkg::VERT_START_ADDR;
            wr_data <= 8'(tm.vert_start);
            wr_start <= 1'b1;
            cfg_step <= 2'h1;
          end
        end
        2'h1: begin
          if (!wr_start && !wr_busy) begin
            wr_addr <= panel_timing_pkg::HORIZ_START_ADDR;
            wr_data <= 8'(tm.data_start);
            wr_start <= 1'b1;
            cfg_step <= 2'h2;
          end
        end
        2'h2: begin
          if (!wr_start && !wr_busy)
            cfg_step <= 2'h0;
        end
        default: cfg_step <= 2'h0;
      endcase
    end
  end

  serial_reg_writer u_ser (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(clk_en),
    .start(wr_start),
    .addr(wr_addr),
    .data(wr_data),
    .busy(wr_busy),
    .ser_cs_n(ser_cs_n),
    .ser_clk(ser_clk),
    .ser_dat_o(ser_dat_o),
    .ser_dat_oe(ser_dat_oe)
  );
endmodule

// File: bench/panel_host_asserts.sv
`timescale 1ns/100ps
module panel_host_asserts #(
  parameter int PIXEL_DIV = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Panel pins
  input wire logic panel_reset_n,
  input wire logic pixel_clk,
  input wire logic vsync_n,
  input wire logic hsync_n,
  input wire panel_timing_pkg::pixel_s rgb,
  input wire logic scan_direction_sel,
  input wire logic ser_cs_n,
  input wire logic ser_dat_oe,
  // Status
  input wire logic pixel_req,
  input wire logic cfg_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Pixel clock idle counter
  // ****************************************
  int idle;
  logic pclk_d;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle <= 0;
      pclk_d <= 1'b0;
    end else begin
      pclk_d <= pixel_clk;
      if (!clk_en || pixel_clk != pclk_d) idle <= 0;
      else idle <= idle + 1;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_pclk_runs: assert property (idle < PIXEL_DIV / 2 + 3)
    else $error("pixel clock stopped");
  a_reset_idle: assert property ($rose(resetn) |->
    vsync_n && hsync_n && ser_cs_n && rgb == '0)
    else $error("outputs not idle at reset release");
  a_sync_phase: assert property ($fell(vsync_n) |-> $fell(hsync_n))
    else $error("hsync fall outside vsync window");
  a_blank_vsync: assert property (!vsync_n |-> rgb == '0)
    else $error("pixel data during vertical sync");
  a_blank_hsync: assert property (!hsync_n |-> rgb == '0)
    else $error("pixel data during line sync");
  a_data_edge: assert property ($rose(pixel_clk) |-> $stable(rgb))
    else $error("pixel data moved on sampling edge");
  a_cs_frame: assert property ($fell(ser_cs_n) |-> ser_dat_oe && cfg_busy)
    else $error("serial frame without drive or busy");
  a_cs_length: assert property ($fell(ser_cs_n) |->
    ##255 !ser_cs_n ##[1:64] ser_cs_n)
    else $error("serial frame length wrong");
  a_scan_fixed: assert property ($changed(scan_direction_sel)
    |-> !$past(panel_reset_n))
    else $error("scan select moved while running");
  a_req_pulse: assert property (pixel_req |=> !pixel_req)
    else $error("pixel request longer than one cycle");
  c_vsync: cover property ($fell(vsync_n));
  c_serial: cover property ($fell(ser_cs_n));
  c_data: cover property (rgb != '0 ##1 rgb == '0);
endmodule
bind rgb_panel_timing_host panel_host_asserts #(.PIXEL_DIV(PIXEL_DIV)) chk (
  .clk_sys, .resetn, .clk_en, .panel_reset_n, .pixel_clk, .vsync_n,
  .hsync_n, .rgb, .scan_direction_sel, .ser_cs_n, .ser_dat_oe,
  .pixel_req, .cfg_busy);

// File: bench/panel_model.sv
`timescale 1ns/100ps
module panel_model (
  // Panel pins
  input wire logic rst_n,
  input wire logic pixel_clk,
  input wire logic vsync_n,
  input wire logic hsync_n,
  input wire panel_timing_pkg::pixel_s rgb,
  input wire logic ser_cs_n,
  input wire logic ser_clk,
  input wire logic ser_dat,
  // Measurements
  output int line_cnt,
  output int line_total,
  output int sync_w,
  output int data_start,
  output int act_px,
  output int first_line,
  output int vs_lines,
  output int n_wr,
  output logic [7:0] vert_start_reg,
  output logic [7:0] horiz_start_reg,
  output panel_timing_pkg::pixel_s last_px
);
  int hc, sc, ac, ds, vc, nfall;
  logic hs_d, vs_d, seen, found, disp_on;
  logic [15:0] sh;
  int nb;
  // ****************************************
  // Pixel side, sampled on rising pixel clock
  // ****************************************
  always @(posedge pixel_clk or negedge rst_n) begin
    if (!rst_n) begin
      {hc, vc, nfall, line_cnt} <= '0;
      {seen, found, disp_on} <= '0;
      {hs_d, vs_d} <= 2'b11;
    end else begin
      hs_d <= hsync_n;
      vs_d <= vsync_n;
      hc <= hc + 1;
      if (!hsync_n) sc <= sc + 1;
      if (rgb != '0) begin
        ac <= ac + 1;
        last_px <= rgb;
        if (ac == 0) ds <= hc;
      end
      if (hs_d && !hsync_n) begin
        if (seen) begin
          line_cnt <= line_cnt + 1;
          {line_total, sync_w, act_px, data_start} <= {hc, sc, ac, ds};
          if (ac > 0 && !found) begin
            first_line <= vc;
            found <= 1'b1;
          end
        end
        seen <= 1'b1;
        {hc, sc, ac} <= {32'd1, 32'd1, 32'd0};
        vc <= vc + 1;
        if (!vsync_n) vs_lines <= vs_lines + 1;
      end
      if (vs_d && !vsync_n) begin
        {vc, vs_lines} <= {32'd0, 32'd1};
        found <= 1'b0;
        nfall <= nfall + 1;
        if (nfall + 1 >= 10) disp_on <= 1'b1;
      end
    end
  end
  // ****************************************
  // Serial register port
  // ****************************************
  always @(posedge ser_clk or posedge ser_cs_n) begin
    if (ser_cs_n) nb <= 0;
    else begin
      sh <= {sh[14:0], ser_dat};
      nb <= nb + 1;
      if (nb == 15) begin
        n_wr <= n_wr + 1;
        if (sh[13:7] == panel_timing_pkg::VERT_START_ADDR)
          vert_start_reg <= {sh[6:0], ser_dat};
        if (sh[13:7] == panel_timing_pkg::HORIZ_START_ADDR)
          horiz_start_reg <= {sh[6:0], ser_dat};
      end
    end
  end
endmodule

// File: bench/rgb_panel_timing_host_bench.sv
`timescale 1ns/100ps
module rgb_panel_timing_host_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic enable = 1'b0;
  logic scan_dir = 1'b0;
  logic cfg_write = 1'b0;
  panel_timing_pkg::timing_s timing_in = '0;
  panel_timing_pkg::pixel_s pixel_in = '0;
  panel_timing_pkg::pixel_s rgb, last_px;
  logic pixel_req, cfg_busy, panel_reset_n, pixel_clk, vsync_n, hsync_n;
  logic scan_direction_sel, ser_cs_n, ser_clk, ser_dat_o, ser_dat_oe;
  logic [7:0] vert_start_reg, horiz_start_reg;
  int line_cnt, line_total, sync_w, data_start, act_px;
  int first_line, vs_lines, n_wr;
  logic [8:0] pixel_x, pixel_y;
  int exp_x = 0;
  int exp_y = 0;
  int fails = 0;
  int n_checks = 0;
  int unsigned seed = 42;
  int tm [2][6] = '{'{280, 10, 30, 326, 2, 4}, '{270, 8, 26, 323, 1, 2}};
  initial forever #5 clk_sys = ~clk_sys;
  rgb_panel_timing_host #(.PIXEL_DIV(2)) uut (
    .clk_sys, .resetn, .clk_en(1'b1), .enable, .power_down_req(1'b0),
    .scan_dir, .timing_in, .cfg_write, .pixel_in, .pixel_req,
    .pixel_x, .pixel_y, .power_down_ok(), .cfg_busy, .panel_reset_n,
    .pixel_clk, .vsync_n, .hsync_n, .rgb, .scan_direction_sel, .ser_cs_n,
    .ser_clk, .ser_dat_o, .ser_dat_oe);
  panel_model panel (
    .rst_n(panel_reset_n), .pixel_clk, .vsync_n, .hsync_n, .rgb,
    .ser_cs_n, .ser_clk, .ser_dat(ser_dat_o), .line_cnt, .line_total,
    .sync_w, .data_start, .act_px, .first_line, .vs_lines, .n_wr,
    .vert_start_reg, .horiz_start_reg, .last_px);
  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Pixel position follows raster order from the first frame
  always @(posedge clk_sys) begin
    if (resetn !== 1'b1) begin
      exp_x = 0;
      exp_y = 0;
    end else if (pixel_req === 1'b1) begin
      chk("pixel x", exp_x, pixel_x);
      chk("pixel y", exp_y, pixel_y);
      exp_y = (exp_x == 239) ? exp_y + 1 : exp_y;
      exp_x = (exp_x == 239) ? 0 : exp_x + 1;
    end
  end
  task close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wait_for(int tgt, bit cfg);
    for (int c = 0; c < 20000; c++) begin
      @(posedge clk_sys);
      if (cfg ? cfg_busy === 1'b0 : line_cnt >= tgt) return;
    end
    fails++;
    $display("Error wait ran out");
    close_out();
  endtask
  // ****************************************
  // Minimum and typical timing, one reset each
  // ****************************************
  initial begin
    for (int s = 0; s < 2; s++) begin
      resetn <= 1'b0;
      enable <= 1'b0;
      scan_dir <= 1'(rnd());
      pixel_in <= panel_timing_pkg::pixel_s'(rnd() | 1);
      timing_in <= '{9'(tm[s][0]), 6'(tm[s][1]), 6'(tm[s][2]),
        9'(tm[s][3]), 4'(tm[s][4]), 4'(tm[s][5])};
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      enable <= 1'b1;
      wait_for(tm[s][5] + 2, 0);
      chk("line total", tm[s][0], line_total);
      chk("sync width", tm[s][1], sync_w);
      chk("data start", tm[s][2], data_start);
      chk("active pixels", 240, act_px);
      chk("first line", tm[s][5], first_line);
      chk("vsync lines", tm[s][4], vs_lines);
      chk("pixel", pixel_in, last_px);
      chk("scan sel", scan_dir, scan_direction_sel);
      scan_dir <= ~scan_dir;
      cfg_write <= 1'b1;
      @(posedge clk_sys);
      cfg_write <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("cfg busy", 1, cfg_busy);
      cfg_write <= 1'b1;
      @(posedge clk_sys);
      cfg_write <= 1'b0;
      wait_for(0, 1);
      chk("write count", 2 * (s + 1), n_wr);
      chk("vert start reg", tm[s][5], vert_start_reg);
      chk("horiz start reg", tm[s][2], horiz_start_reg);
      chk("scan held", !scan_dir, scan_direction_sel);
      $display("timing set %0d done", s);
    end
    close_out();
  end
endmodule
